/* design/dtm_pin_if.sv */
// synchronised pin levels and falling-edge pulses
`timescale 1ns/10ps
interface dtm_pin_if #(parameter int N = 4);
	logic [N-1:0] level;
	logic [N-1:0] fall;
	modport src (output level, output fall);
	modport dst (input level, input fall);
endinterface

/* design/dtm_pin_sync.sv */
// three-stage pin synchroniser with agreed level and falling-edge pulse
`timescale 1ns/10ps
module dtm_pin_sync #(parameter int N = 4) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [N-1:0] pins,
	dtm_pin_if.src out
);
	logic [N-1:0] s1_r, s2_r, s3_r, lvl_r, fall_r;
	logic [N-1:0] lvl_nxt, fall_nxt;

	// ----------------------------------------
	// a change counts only when stages two and three agree
	// ----------------------------------------
	always_comb begin
		lvl_nxt = lvl_r;
		fall_nxt = '0;
		for (int i = 0; i < N; i++) begin
			if (s2_r[i] == s3_r[i]) begin
				lvl_nxt[i] = s3_r[i];
				fall_nxt[i] = lvl_r[i] & ~s3_r[i];
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			lvl_r <= '0;
			fall_r <= '0;
		end else begin
			s1_r <= pins;
			s2_r <= s1_r;
			s3_r <= s2_r;
			lvl_r <= lvl_nxt;
			fall_r <= fall_nxt;
		end
	end

	assign out.level = lvl_r;
	assign out.fall = fall_r;
endmodule

/* design/dtm_pkg.sv */
// shared constants and types for the dual timer mode control block
package dtm_pkg;

	// ----------------------------------------
	// bus geometry and responses
	// ----------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// register indices, byte address is four times the index
	// ----------------------------------------
	localparam logic [7:0] IDX_MODE_CTRL = 8'h89;
	localparam logic [7:0] IDX_LO_A = 8'h8a;
	localparam logic [7:0] IDX_TL1 = 8'h8b;
	localparam logic [7:0] IDX_TH0 = 8'h8c;
	localparam logic [7:0] IDX_TH1 = 8'h8d;
	localparam logic [7:0] IDX_RUN_CTRL = 8'h8e;
	localparam logic [7:0] IDX_STATUS = 8'h8f;
	localparam logic [7:0] REG_RST = 8'h00;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int MB_GATE_B = 7;
	localparam int MB_SRC_B = 6;
	localparam int MB_MODE_B = 4;
	localparam int MB_GATE_A = 3;
	localparam int MB_SRC_A = 2;
	localparam int MB_MODE_A = 0;
	localparam int RB_RUN_A = 0;
	localparam int RB_RUN_B = 1;
	localparam int RB_POL_A = 2;
	localparam int RB_POL_B = 3;
	localparam int SB_OVF_A = 0;
	localparam int SB_OVF_B = 1;

	// ----------------------------------------
	// pins and timing
	// ----------------------------------------
	localparam int NPINS = 4;
	localparam int PIN_CNT_A = 0;
	localparam int PIN_CNT_B = 1;
	localparam int PIN_IRQ_A = 2;
	localparam int PIN_IRQ_B = 3;
	localparam int PRESCALE_DEF = 12;
	localparam int PRE_W = 8;

	typedef enum logic [1:0] {
		DTM_MODE_13 = 2'b00,
		DTM_MODE_16 = 2'b01,
		DTM_MODE_RLD = 2'b10,
		DTM_MODE_SPLIT = 2'b11
	} dtm_mode_t;

endpackage

/* design/dtm_timer_top.sv */
// dual counter/timer with mode control register behind an axi4-lite slave
`timescale 1ns/10ps
module dtm_timer_top #(
	parameter int PRESCALE = dtm_pkg::PRESCALE_DEF
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic tmr_a_count_pin,
	input wire logic tmr_b_count_pin,
	input wire logic ext_irq_a_pin,
	input wire logic ext_irq_b_pin,
	input wire logic [dtm_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [dtm_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [dtm_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [dtm_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import dtm_pkg::*;

	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRESCALE - 1);

	// ----------------------------------------
	// helper functions
	// ----------------------------------------
	function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
		addr_hit = (a[ADDR_W-1:10] == '0) && (a[9:2] >= IDX_MODE_CTRL)
			&& (a[9:2] <= IDX_STATUS);
	endfunction

	// one increment of a low/high byte pair; result is {carry, hi, lo}
	function automatic logic [16:0] step(input dtm_mode_t m,
		input logic [7:0] lo, input logic [7:0] hi);
		logic [13:0] s13;
		logic [16:0] s16;
		logic [8:0] s8;
		s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
		s16 = {1'b0, hi, lo} + 17'h0_0001;
		s8 = {1'b0, lo} + 9'h001;
		case (m)
		DTM_MODE_13: begin
			// upper three low bits hold their value
			step = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
		end
		DTM_MODE_16: begin
			step = s16;
		end
		DTM_MODE_RLD: begin
			step = {s8[8], hi, s8[8] ? hi : s8[7:0]};
		end
		default: begin
			step = {1'b0, hi, lo};
		end
		endcase
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	dtm_pin_if #(.N(NPINS)) pin ();
	logic [NPINS-1:0] pins_raw;

	always_comb begin
		pins_raw = '0;
		pins_raw[PIN_CNT_A] = tmr_a_count_pin;
		pins_raw[PIN_CNT_B] = tmr_b_count_pin;
		pins_raw[PIN_IRQ_A] = ext_irq_a_pin;
		pins_raw[PIN_IRQ_B] = ext_irq_b_pin;
	end

	dtm_pin_sync #(.N(NPINS)) u_sync (
		.clk(clk),
		.nrst(nrst),
		.pins(pins_raw),
		.out(pin.src)
	);

	// ----------------------------------------
	// bus slave state
	// ----------------------------------------
	logic awready_r, awready_nxt, wready_r, wready_nxt;
	logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
	logic [ADDR_W-1:0] waddr_r, waddr_nxt;
	logic [7:0] wbyte_r, wbyte_nxt;
	logic wen_r, wen_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
	logic [DATA_W-1:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	logic wr_do;
	logic [7:0] wr_idx;

	// ----------------------------------------
	// timer state
	// ----------------------------------------
	logic [7:0] mode_r, mode_nxt, run_r, run_nxt;
	logic [7:0] lo_a_r, lo_a_nxt, th0_r, th0_nxt;
	logic [7:0] tl1_r, tl1_nxt, th1_r, th1_nxt;
	logic [1:0] ovf_r, ovf_nxt;
	logic [PRE_W-1:0] pre_r, pre_nxt;

	function automatic logic [7:0] read_reg(input logic [7:0] idx);
		case (idx)
		IDX_MODE_CTRL: read_reg = mode_r;
		IDX_LO_A: read_reg = lo_a_r;
		IDX_TL1: read_reg = tl1_r;
		IDX_TH0: read_reg = th0_r;
		IDX_TH1: read_reg = th1_r;
		IDX_RUN_CTRL: read_reg = run_r;
		IDX_STATUS: read_reg = {6'h00, ovf_r};
		default: read_reg = REG_RST;
		endcase
	endfunction

	// ----------------------------------------
	// bus slave next state
	// ----------------------------------------
	always_comb begin
		aw_got_nxt = aw_got_r;
		w_got_nxt = w_got_r;
		waddr_nxt = waddr_r;
		wbyte_nxt = wbyte_r;
		wen_nxt = wen_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		wr_do = 1'b0;
		wr_idx = waddr_r[9:2];
		if (s_axi_awvalid && awready_r) begin
			aw_got_nxt = 1'b1;
			waddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_r) begin
			w_got_nxt = 1'b1;
			wbyte_nxt = s_axi_wdata[7:0];
			// narrow registers live in lane zero only
			wen_nxt = s_axi_wstrb[0];
		end
		if (aw_got_r && w_got_r && !bvalid_r) begin
			wr_do = addr_hit(waddr_r) && wen_r;
			aw_got_nxt = 1'b0;
			w_got_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = addr_hit(waddr_r) ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (rvalid_r) begin
			if (s_axi_rready) begin
				rvalid_nxt = 1'b0;
			end
		end else if (s_axi_arvalid && arready_r) begin
			rvalid_nxt = 1'b1;
			rdata_nxt = {24'h00_0000, read_reg(s_axi_araddr[9:2])};
			if (!addr_hit(s_axi_araddr)) begin
				rdata_nxt = '0;
			end
			rresp_nxt = addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		awready_nxt = !aw_got_nxt;
		wready_nxt = !w_got_nxt;
		arready_nxt = !rvalid_nxt;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			waddr_r <= '0;
			wbyte_r <= REG_RST;
			wen_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= RESP_OKAY;
		end else begin
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			waddr_r <= waddr_nxt;
			wbyte_r <= wbyte_nxt;
			wen_r <= wen_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	// ----------------------------------------
	// timer next state
	// ----------------------------------------
	logic tick, act_a, act_b, inc_a, inc_b;
	logic [16:0] res_a, res_b;
	logic [8:0] th0_inc;
	logic [1:0] ovf_set, ovf_clr;
	dtm_mode_t mode_a, mode_b;

	always_comb begin
		mode_a = dtm_mode_t'(mode_r[MB_MODE_A +: 2]);
		mode_b = dtm_mode_t'(mode_r[MB_MODE_B +: 2]);
		tick = (pre_r == PRE_LAST);
		pre_nxt = tick ? '0 : pre_r + PRE_W'(1);
		// gate clear ignores the pin, gate set needs the active level
		act_a = run_r[RB_RUN_A] && (!mode_r[MB_GATE_A]
			|| (pin.level[PIN_IRQ_A] == run_r[RB_POL_A]));
		act_b = run_r[RB_RUN_B] && (!mode_r[MB_GATE_B]
			|| (pin.level[PIN_IRQ_B] == run_r[RB_POL_B]));
		inc_a = act_a && (mode_r[MB_SRC_A] ? pin.fall[PIN_CNT_A] : tick);
		inc_b = act_b && (mode_r[MB_SRC_B] ? pin.fall[PIN_CNT_B] : tick)
			&& (mode_b != DTM_MODE_SPLIT);
		lo_a_nxt = lo_a_r;
		th0_nxt = th0_r;
		tl1_nxt = tl1_r;
		th1_nxt = th1_r;
		ovf_set = 2'h0;
		res_a = step(mode_a, lo_a_r, th0_r);
		res_b = step(mode_b, tl1_r, th1_r);
		th0_inc = {1'b0, th0_r} + 9'h001;
		if (mode_a == DTM_MODE_SPLIT) begin
			// low byte keeps timer a controls, high byte borrows run b
			// a reload of zero turns the low byte into a plain 8-bit wrap
			res_a = step(DTM_MODE_RLD, lo_a_r, '0);
			if (inc_a) begin
				lo_a_nxt = res_a[7:0];
				ovf_set[SB_OVF_A] = res_a[16];
			end
			if (run_r[RB_RUN_B] && tick) begin
				th0_nxt = th0_inc[7:0];
				ovf_set[SB_OVF_B] = th0_inc[8];
			end
		end else if (inc_a) begin
			{ovf_set[SB_OVF_A], th0_nxt, lo_a_nxt} = res_a;
		end
		if (inc_b) begin
			tl1_nxt = res_b[7:0];
			th1_nxt = res_b[15:8];
			// in split mode the flag belongs to the borrowed high byte
			if (mode_a != DTM_MODE_SPLIT) begin
				ovf_set[SB_OVF_B] = res_b[16];
			end
		end
		mode_nxt = mode_r;
		run_nxt = run_r;
		ovf_clr = 2'h0;
		if (wr_do) begin
			// software write to a byte wins over a count in that cycle
			case (wr_idx)
			IDX_MODE_CTRL: mode_nxt = wbyte_r;
			IDX_RUN_CTRL: run_nxt = wbyte_r;
			IDX_LO_A: lo_a_nxt = wbyte_r;
			IDX_TH0: th0_nxt = wbyte_r;
			IDX_TL1: tl1_nxt = wbyte_r;
			IDX_TH1: th1_nxt = wbyte_r;
			IDX_STATUS: ovf_clr = wbyte_r[1:0];
			default: ovf_clr = 2'h0;
			endcase
		end
		// a new overflow beats a clear in the same cycle
		ovf_nxt = (ovf_r & ~ovf_clr) | ovf_set;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mode_r <= REG_RST;
			run_r <= REG_RST;
			lo_a_r <= REG_RST;
			th0_r <= REG_RST;
			tl1_r <= REG_RST;
			th1_r <= REG_RST;
			ovf_r <= 2'h0;
			pre_r <= '0;
		end else begin
			mode_r <= mode_nxt;
			run_r <= run_nxt;
			lo_a_r <= lo_a_nxt;
			th0_r <= th0_nxt;
			tl1_r <= tl1_nxt;
			th1_r <= th1_nxt;
			ovf_r <= ovf_nxt;
			pre_r <= pre_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
endmodule

/* sim/dtm_pin_model.sv */
// far-side model of the count and gate pins
`timescale 1ns/10ps
module dtm_pin_model (
	input wire logic clk,
	output logic tmr_a_count_pin,
	output logic tmr_b_count_pin,
	output logic ext_irq_a_pin,
	output logic ext_irq_b_pin
);
	// ----------------------------------------
	// pin drive
	// ----------------------------------------
	// count pins idle high so that only the commanded falls are seen
	initial begin
		tmr_a_count_pin = 1'h1;
		tmr_b_count_pin = 1'h1;
		ext_irq_a_pin = 1'h0;
		ext_irq_b_pin = 1'h0;
	end

	// each pulse stays low and high long enough to pass the synchroniser
	task automatic pulses(input logic b, input int n);
		repeat (n) begin
			@(posedge clk);
			if (b) tmr_b_count_pin <= 1'h0;
			else tmr_a_count_pin <= 1'h0;
			repeat (4) @(posedge clk);
			tmr_a_count_pin <= 1'h1;
			tmr_b_count_pin <= 1'h1;
			repeat (4) @(posedge clk);
		end
	endtask

	task automatic set_gate(input logic a, input logic b);
		@(posedge clk);
		ext_irq_a_pin <= a;
		ext_irq_b_pin <= b;
		repeat (6) @(posedge clk);
	endtask
endmodule

/* sim/dtm_timer_monitor.sv */
// register bus protocol checker for the dual timer block
`timescale 1ns/10ps
module dtm_timer_monitor (
	input wire logic clk,
	input wire logic nrst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic [dtm_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [dtm_pkg::DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import dtm_pkg::*;
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	property p_wr_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
	property p_rd_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_ar_low;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_low: assert property (p_ar_low) else $error("read taken early");
	// addresses outside the map answer an error with zero data
	property p_unmapped;
		s_axi_arvalid && s_axi_arready && (s_axi_araddr[11:2] < 10'h089 ||
		s_axi_araddr[11:2] > 10'h08f)
		|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("bad unmapped read");
	property p_hi_zero;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000;
	endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
	property p_r_clear;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_r_clear: assert property (p_r_clear) else $error("read answer repeated");
endmodule

bind dtm_timer_top dtm_timer_monitor u_mon (.*);

/* sim/dtm_timer_top_tb.sv */
// self-checking testbench for the dual timer block
`timescale 1ns/10ps
module dtm_timer_top_tb;
	import dtm_pkg::*;
	logic clk, nrst, tmr_a_count_pin, tmr_b_count_pin;
	logic ext_irq_a_pin, ext_irq_b_pin;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	int mismatches = 0;
	int checks = 0;
	logic [31:0] d;
	logic [1:0] r;

	// short prescale keeps internal-tick tests brief
	dtm_timer_top #(.PRESCALE(2)) dut (.*);
	dtm_pin_model pm (.*);

	always #25 clk = ~clk;

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] i, input logic [7:0] v);
		@(posedge clk);
		s_axi_awaddr <= {2'h0, i, 2'h0};
		s_axi_wdata <= {24'h00_0000, v};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		forever begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid === 1'h1) break;
		end
		s_axi_bready <= 1'h0;
		chk(32'(s_axi_bresp), 32'(RESP_OKAY));
	endtask

	task automatic rd(input logic [7:0] i, output logic [31:0] v,
			output logic [1:0] rs);
		@(posedge clk);
		s_axi_araddr <= {2'h0, i, 2'h0};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		forever begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid === 1'h1) break;
		end
		v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask

	task automatic rc(input logic [7:0] i, input logic [7:0] e);
		logic [31:0] v;
		logic [1:0] rs;
		rd(i, v, rs);
		chk(v, {24'h00_0000, e});
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		end_of_test();
	end

	initial begin
		clk = 1'h0;
		nrst = 1'h0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		repeat (5) @(posedge clk);
		nrst <= 1'h1;
		rc(IDX_MODE_CTRL, 8'h00);
		wr(IDX_MODE_CTRL, 8'ha5);
		rc(IDX_MODE_CTRL, 8'ha5);
		rd(8'h90, d, r);
		chk(32'(r), 32'(RESP_SLVERR));
		$display("register test done");
		// internal tick: prescale of two gives about one count per two clocks
		wr(IDX_MODE_CTRL, 8'h01);
		wr(IDX_LO_A, 8'h00);
		wr(IDX_RUN_CTRL, 8'h01);
		repeat (40) @(posedge clk);
		rd(IDX_LO_A, d, r);
		chk(32'(d[7:0] >= 8'h12 && d[7:0] <= 8'h1a), 32'h0000_0001);
		wr(IDX_RUN_CTRL, 8'h00);
		// timer a counts pin falls, 16-bit carry
		wr(IDX_MODE_CTRL, 8'h05);
		wr(IDX_LO_A, 8'hff);
		wr(IDX_TH0, 8'h00);
		wr(IDX_RUN_CTRL, 8'h01);
		pm.pulses(1'h0, 3);
		rc(IDX_LO_A, 8'h02);
		rc(IDX_TH0, 8'h01);
		// 13-bit: five low bits roll into the high byte
		wr(IDX_MODE_CTRL, 8'h04);
		wr(IDX_LO_A, 8'h1f);
		pm.pulses(1'h0, 1);
		rd(IDX_LO_A, d, r);
		chk(32'(d[4:0]), 32'h0000_0000);
		rc(IDX_TH0, 8'h02);
		// all 13 bits wrap and raise the overflow flag
		wr(IDX_TH0, 8'hff);
		wr(IDX_LO_A, 8'h1f);
		pm.pulses(1'h0, 1);
		rc(IDX_TH0, 8'h00);
		rc(IDX_STATUS, 8'h01);
		wr(IDX_STATUS, 8'h01);
		// reload from an unchanged high byte
		wr(IDX_MODE_CTRL, 8'h06);
		wr(IDX_TH0, 8'hfe);
		wr(IDX_LO_A, 8'hfe);
		pm.pulses(1'h0, 3);
		rc(IDX_LO_A, 8'hff);
		rc(IDX_TH0, 8'hfe);
		rc(IDX_STATUS, 8'h01);
		wr(IDX_STATUS, 8'h01);
		// gate a needs the pin at its active level
		wr(IDX_MODE_CTRL, 8'h0d);
		wr(IDX_LO_A, 8'h00);
		wr(IDX_RUN_CTRL, 8'h05);
		pm.pulses(1'h0, 2);
		rc(IDX_LO_A, 8'h00);
		pm.set_gate(1'h1, 1'h0);
		pm.pulses(1'h0, 2);
		rc(IDX_LO_A, 8'h02);
		$display("timer a test done");
		// timer b: free, then gated
		wr(IDX_MODE_CTRL, 8'h50);
		wr(IDX_TL1, 8'h00);
		wr(IDX_RUN_CTRL, 8'h02);
		pm.pulses(1'h1, 3);
		rc(IDX_TL1, 8'h03);
		wr(IDX_MODE_CTRL, 8'hd0);
		wr(IDX_RUN_CTRL, 8'h0a);
		pm.set_gate(1'h0, 1'h0);
		pm.pulses(1'h1, 2);
		rc(IDX_TL1, 8'h03);
		pm.set_gate(1'h0, 1'h1);
		pm.pulses(1'h1, 1);
		rc(IDX_TL1, 8'h04);
		// mode 11 stops timer b
		wr(IDX_MODE_CTRL, 8'h70);
		pm.pulses(1'h1, 2);
		rc(IDX_TL1, 8'h04);
		// timer b reload mode from its pin
		wr(IDX_MODE_CTRL, 8'h60);
		wr(IDX_TH1, 8'hfc);
		wr(IDX_TL1, 8'hfe);
		pm.pulses(1'h1, 3);
		rc(IDX_TL1, 8'hfd);
		rc(IDX_TH1, 8'hfc);
		rc(IDX_STATUS, 8'h02);
		$display("timer b test done");
		// split: high byte runs on run b alone, low byte held by run a
		wr(IDX_MODE_CTRL, 8'h07);
		wr(IDX_LO_A, 8'h00);
		wr(IDX_TH0, 8'h00);
		wr(IDX_RUN_CTRL, 8'h02);
		repeat (20) @(posedge clk);
		rd(IDX_TH0, d, r);
		chk(32'(d[7:0] != 8'h00), 32'h0000_0001);
		rc(IDX_LO_A, 8'h00);
		// the low byte wraps as a plain 8-bit counter
		wr(IDX_LO_A, 8'hff);
		wr(IDX_RUN_CTRL, 8'h03);
		pm.pulses(1'h0, 1);
		rc(IDX_LO_A, 8'h00);
		rd(IDX_STATUS, d, r);
		chk(32'(d[0]), 32'h0000_0001);
		$display("split test done");
		end_of_test();
	end
endmodule
